// File: core/option_byte_regs.vh
`ifndef OPTION_BYTE_REGS_VH
`define OPTION_BYTE_REGS_VH
// ==========================================================
// option byte zero field positions
`define OB0_HALT_WDG_BIT 7
`define OB0_WDG_TYPE_BIT 6
`define OB0_CLK_GUARD_BIT 5
`define OB0_VD_HI 4
`define OB0_VD_LO 3
`define OB0_RSVD_HI 2
`define OB0_RSVD_LO 1
`define OB0_READOUT_BIT 0
// ==========================================================
// option byte one field positions
`define OB1_PKG_BIT 7
`define OB1_RESET_CYCLE_SELECT_BIT 6
`define OB1_OSC_HI 5
`define OB1_OSC_LO 4
`define OB1_RANGE_HI 3
`define OB1_RANGE_LO 1
`define OB1_PLL_OFF_BIT 0
// ==========================================================
// values
`define OPT_ERASED 8'hFF
`define OPT_READ_IDLE 8'h00
`define OB0_DEFAULT 8'hE7
`define OB1_DEFAULT_LOW 7'h67
`define OSC_RESONATOR 2'h0
`define OSC_RESERVED 2'h1
`define OSC_INT_RC 2'h2
`define OSC_EXTERNAL 2'h3
`define VD_OFF 2'h3
`define RANGE_2_4MHZ 3'h1
`define RESET_CYCLES_LONG 13'h1000
`define RESET_CYCLES_SHORT 13'h0100
`endif

// File: core/option_byte_config_decoder.v
`include "option_byte_regs.vh"
module option_byte_config_decoder #(
  parameter PACKAGE_BIT = 1'b1
) (
  input wire clk,
  input wire rst,
  input wire prog_mode,
  input wire prog_sel,
  input wire prog_wr,
  input wire [7:0] prog_wdata,
  output wire [7:0] prog_rdata,
  input wire prog_erase,
  output reg user_mem_erase_req,
  input wire halt_entry,
  input wire watchdog_active,
  output reg halt_reset_req,
  output reg halt_watchdog_reset_select,
  output reg watchdog_type_select,
  output reg watchdog_always_on,
  output reg clock_guard_enable,
  output reg [1:0] voltage_detect_level,
  output reg low_supply_detector_en,
  output reg aux_supply_detector_en,
  output reg readout_lock,
  output reg flash_write_block,
  output reg package_select,
  output reg reset_cycle_select,
  output reg [12:0] reset_phase_cycles,
  output reg [1:0] osc_source_select,
  output reg [2:0] osc_drive_range,
  output reg clock_doubler_disable,
  output reg clock_doubler_en,
  output reg unbonded_pad_pullup
);
  // ==========================================================
  // non-volatile store
  reg [7:0] option_byte_zero;
  reg [7:0] option_byte_one;
  reg [7:0] nxt_zero;
  reg [7:0] nxt_one;
  reg prog_mode_m_ff;
  reg prog_mode_ff;

  // programming mode pin synchroniser
  always @(posedge clk) begin
    if (rst) begin
      prog_mode_m_ff <= 1'b0;
      prog_mode_ff <= 1'b0;
    end else begin
      prog_mode_m_ff <= prog_mode;
      prog_mode_ff <= prog_mode_m_ff;
    end
  end

  // writes and erase only through the programming port
  always @* begin
    nxt_zero = option_byte_zero;
    nxt_one = option_byte_one;
    if (prog_mode_ff && prog_erase) begin
      nxt_zero = `OPT_ERASED;
      nxt_one = `OPT_ERASED;
    end else if (prog_mode_ff && prog_wr) begin
      if (prog_sel)
        nxt_one = prog_wdata;
      else
        nxt_zero = prog_wdata;
    end
  end

  // storage holds across reset; initial is the shipped content
  initial begin
    option_byte_zero = `OB0_DEFAULT;
    option_byte_one = {PACKAGE_BIT[0], `OB1_DEFAULT_LOW};
  end
  always @(posedge clk) begin
    option_byte_zero <= nxt_zero;
    option_byte_one <= nxt_one;
  end

  // read port answers only in programming mode
  assign prog_rdata = !prog_mode_ff ? `OPT_READ_IDLE :
    (prog_sel ? option_byte_one : option_byte_zero);

  // user memory wipe requested in the same cycle as an option erase made while the readout bit is cleared
  always @(posedge clk) begin
    if (rst)
      user_mem_erase_req <= 1'b0;
    else
      user_mem_erase_req <= prog_mode_ff && prog_erase &&
        !option_byte_zero[`OB0_READOUT_BIT];
  end

  // ==========================================================
  // shared decode helpers

  // supply detectors run unless the level field holds the off code
  function supply_detect_on;
    input [1:0] level;
    begin
      supply_detect_on = (level != `VD_OFF);
    end
  endfunction

  // inverted option bits: a cleared bit turns the feature on
  function bit_active_low;
    input opt_bit;
    begin
      bit_active_low = !opt_bit;
    end
  endfunction

  // reset phase length picked by the cycle select bit
  function [12:0] phase_length;
    input short_sel;
    begin
      if (short_sel)
        phase_length = `RESET_CYCLES_SHORT;
      else
        phase_length = `RESET_CYCLES_LONG;
    end
  endfunction

  // ==========================================================
  // decode, captured while reset is held and frozen after it, except the halt request

  // watchdog selections from byte zero
  always @(posedge clk) begin
    if (rst) begin
      halt_watchdog_reset_select <= option_byte_zero[`OB0_HALT_WDG_BIT];
      watchdog_type_select <= option_byte_zero[`OB0_WDG_TYPE_BIT];
      watchdog_always_on <=
        bit_active_low(option_byte_zero[`OB0_WDG_TYPE_BIT]);
    end
  end

  // clock guard runs when its option bit is cleared
  always @(posedge clk) begin
    if (rst) begin
      clock_guard_enable <=
        bit_active_low(option_byte_zero[`OB0_CLK_GUARD_BIT]);
    end
  end

  // supply detector threshold and enables
  always @(posedge clk) begin
    if (rst) begin
      voltage_detect_level <= option_byte_zero[`OB0_VD_HI:`OB0_VD_LO];
      low_supply_detector_en <=
        supply_detect_on(option_byte_zero[`OB0_VD_HI:`OB0_VD_LO]);
      aux_supply_detector_en <=
        supply_detect_on(option_byte_zero[`OB0_VD_HI:`OB0_VD_LO]);
    end
  end

  // readout lock and the flash write block that is its inverse
  always @(posedge clk) begin
    if (rst) begin
      readout_lock <= option_byte_zero[`OB0_READOUT_BIT];
      flash_write_block <=
        bit_active_low(option_byte_zero[`OB0_READOUT_BIT]);
    end
  end

  // package variant bit, preset per device type by PACKAGE_BIT and rewritable through the programming port
  always @(posedge clk) begin
    if (rst) begin
      package_select <= option_byte_one[`OB1_PKG_BIT];
    end
  end

  // reset phase and halt exit length
  always @(posedge clk) begin
    if (rst) begin
      reset_cycle_select <= option_byte_one[`OB1_RESET_CYCLE_SELECT_BIT];
      reset_phase_cycles <=
        phase_length(option_byte_one[`OB1_RESET_CYCLE_SELECT_BIT]);
    end
  end

  // main clock source and resonator drive range
  always @(posedge clk) begin
    if (rst) begin
      osc_source_select <=
        option_byte_one[`OB1_OSC_HI:`OB1_OSC_LO];
      osc_drive_range <=
        option_byte_one[`OB1_RANGE_HI:`OB1_RANGE_LO];
    end
  end

  // clock doubler selection
  always @(posedge clk) begin
    if (rst) begin
      clock_doubler_disable <= option_byte_one[`OB1_PLL_OFF_BIT];
      clock_doubler_en <=
        bit_active_low(option_byte_one[`OB1_PLL_OFF_BIT]);
    end
  end

  // unbonded pads come out of reset as pulled-up inputs
  always @(posedge clk) begin
    if (rst) begin
      unbonded_pad_pullup <= 1'b1;
    end
  end

  // halt entry reset request
  always @(posedge clk) begin
    if (rst)
      halt_reset_req <= 1'b0;
    else
      halt_reset_req <= halt_entry && watchdog_active &&
        halt_watchdog_reset_select;
  end
endmodule // option_byte_config_decoder

// File: verif/option_byte_config_decoder_assertions.sv
// ====
// port checker
module cfg_checker (
  input logic clk,
  input logic rst,
  input logic prog_mode,
  input logic halt_entry,
  input logic watchdog_active,
  input logic halt_reset_req,
  input logic halt_watchdog_reset_select,
  input logic watchdog_type_select,
  input logic watchdog_always_on,
  input logic readout_lock,
  input logic flash_write_block,
  input logic reset_cycle_select,
  input logic [7:0] prog_rdata,
  input logic [12:0] reset_phase_cycles,
  input logic [1:0] voltage_detect_level,
  input logic low_supply_detector_en,
  input logic aux_supply_detector_en,
  input logic clock_doubler_disable,
  input logic clock_doubler_en,
  input logic unbonded_pad_pullup
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_halt; halt_entry && watchdog_active; endsequence
  a_halt_rst: assert property (s_halt |=>
    halt_reset_req == halt_watchdog_reset_select) else $error("halt");
  a_halt_idle: assert property (!halt_entry |=> !halt_reset_req)
    else $error("idle");
  a_halt_dog: assert property (!watchdog_active |=> !halt_reset_req)
    else $error("dog");
  a_wdg_kind: assert property (
    watchdog_always_on != watchdog_type_select) else $error("wdg");
  a_lock_wr: assert property (flash_write_block != readout_lock)
    else $error("lock");
  a_reset_len: assert property (reset_phase_cycles ==
    (reset_cycle_select ? 13'h0100 : 13'h1000)) else $error("len");
  a_cfg_static: assert property (!$past(rst) |->
    $stable({reset_phase_cycles, readout_lock})) else $error("cfg");
  a_read_off: assert property (!prog_mode [*3] |->
    prog_rdata == 8'h00) else $error("read");
  a_supply_level: assert property (
    low_supply_detector_en == (voltage_detect_level != 2'h3))
    else $error("supply");
  a_supply_pair: assert property (
    aux_supply_detector_en == low_supply_detector_en) else $error("aux");
  a_doubler_sel: assert property (
    clock_doubler_en != clock_doubler_disable) else $error("doubler");
  a_pad_pullup: assert property (unbonded_pad_pullup)
    else $error("pad");
endmodule // cfg_checker
bind option_byte_config_decoder cfg_checker chk (.*);

// File: verif/prog_tool.sv
// ====
// programming tool
module prog_tool (
  input logic clk,
  output logic prog_mode,
  output logic prog_sel,
  output logic prog_wr,
  output logic prog_erase,
  output logic [7:0] prog_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {prog_mode, prog_sel, prog_wr, prog_erase, prog_wdata} = 12'h000;
  // mode level, then wait out the two-stage synchroniser
  task automatic mode(input logic m);
    @(posedge clk);
    prog_mode <= m;
    repeat (3) @(posedge clk);
  endtask
  // one write or erase strobe; data scrambled once released
  task automatic put(input logic e, s, input logic [7:0] d);
    @(posedge clk);
    {prog_erase, prog_wr, prog_sel} <= {e, !e, s};
    prog_wdata <= s ? d : d | 8'h06;
    @(posedge clk);
    {prog_erase, prog_wr, prog_wdata} <= {2'h0, ~prog_wdata};
  endtask
endmodule // prog_tool

// File: verif/option_byte_config_decoder_tb.sv
// ====
// bench top
module option_byte_config_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, halt_entry = 1'b0, watchdog_active = 1'b0;
  int fails = 0, num_checks = 0;
  wire prog_mode, prog_sel, prog_wr, prog_erase, user_mem_erase_req;
  wire [7:0] prog_wdata, prog_rdata;
  wire [12:0] reset_phase_cycles;
  wire [2:0] osc_drive_range;
  wire [1:0] voltage_detect_level, osc_source_select;
  wire halt_reset_req, halt_watchdog_reset_select, watchdog_type_select;
  wire watchdog_always_on, clock_guard_enable, low_supply_detector_en;
  wire aux_supply_detector_en, readout_lock, flash_write_block;
  wire package_select, reset_cycle_select, clock_doubler_disable;
  wire clock_doubler_en, unbonded_pad_pullup;
  // decoded settings packed back in option byte order
  wire [13:0] dec = {halt_watchdog_reset_select, watchdog_type_select,
    ~clock_guard_enable, voltage_detect_level, readout_lock, package_select,
    reset_cycle_select, osc_source_select, osc_drive_range,
    clock_doubler_disable};
  // derived enables that invert or summarise option fields, and the fixed unbonded pad pull-up
  wire [6:0] drv = {watchdog_always_on, clock_guard_enable,
    low_supply_detector_en, aux_supply_detector_en, flash_write_block,
    clock_doubler_en, unbonded_pad_pullup};
  always #50 clk = ~clk;
  prog_tool pt (.*);
  option_byte_config_decoder dut (.*);
  // compare and count
  task automatic cmp(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  // synchronous reset for three cycles
  task automatic reset_pulse();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask
  // shipped settings, halt entry, write outside programming mode
  task automatic t_ship();
    cmp(dec, 16'h39E7);
    cmp(drv, 16'h0019);
    cmp(reset_phase_cycles, 16'h0100);
    @(posedge clk);
    {halt_entry, watchdog_active} <= 2'h3;
    @(posedge clk);
    {halt_entry, watchdog_active} <= 2'h0;
    #1;
    cmp(halt_reset_req, 16'h0001);
    pt.put(1'b0, 1'b1, 8'h00);
  endtask
  // byte one read back at once, decoded after reset, erase with the readout bit cleared
  task automatic t_prog();
    pt.mode(1'b1);
    #1;
    cmp(prog_rdata, 16'h00E7);
    pt.put(1'b0, 1'b0, 8'h10);
    pt.put(1'b0, 1'b1, 8'h82);
    #1;
    cmp(prog_rdata, 16'h0082);
    cmp(dec, 16'h39E7);
    reset_pulse();
    cmp(dec, 16'h0482);
    cmp(drv, 16'h007F);
    cmp(reset_phase_cycles, 16'h1000);
    @(posedge clk);
    {halt_entry, watchdog_active} <= 2'h3;
    @(posedge clk);
    {halt_entry, watchdog_active} <= 2'h0;
    #1;
    cmp(halt_reset_req, 16'h0000);
    pt.mode(1'b1);
    pt.put(1'b1, 1'b0, 8'h00);
    #1;
    cmp(user_mem_erase_req, 16'h0001);
    cmp(prog_rdata, 16'h00FF);
    pt.mode(1'b0);
  endtask
  // external clock with its 2-4 MHz range code, decoded after reset
  task automatic t_ext();
    pt.mode(1'b1);
    pt.put(1'b0, 1'b1, 8'hB3);
    #1;
    cmp(prog_rdata, 16'h00B3);
    reset_pulse();
    cmp(dec, 16'h3FB3);
    cmp(drv, 16'h0001);
    cmp(reset_phase_cycles, 16'h1000);
    pt.mode(1'b0);
    #1;
    cmp(prog_rdata, 16'h0000);
  endtask
  // counts and verdict
  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_ship();
    t_prog();
    t_ext();
    print_verdict();
  end
endmodule // option_byte_config_decoder_tb
